// ==== rtl/pdo_pkg.sv ====
// Purpose: shared constants and helpers for the pwm dim and override controller
// Assumes: 100 MHz pclk, registers reached over apb, one 32-bit word per register
// Notes: percent values are 7 bits wide, 0 to 100
package pdo_pkg;
    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_TICK_NS = 1_000_000;
    localparam int unsigned MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam logic [26:0] ACC_WRAP = 27'h5f5e100;
    localparam logic [26:0] DUTY_STEP = 27'h00f4240;
    // register offsets
    localparam logic [7:0] OFF_DIM = 8'h00;
    localparam logic [7:0] OFF_BLINK = 8'h04;
    localparam logic [7:0] OFF_CURVE = 8'h08;
    localparam logic [7:0] OFF_RAMP = 8'h0c;
    localparam logic [7:0] OFF_FREQ = 8'h10;
    localparam logic [7:0] OFF_MIX = 8'h14;
    localparam logic [7:0] OFF_AUXMODE = 8'h18;
    localparam logic [7:0] OFF_DIRECT0 = 8'h20;
    localparam logic [7:0] OFF_SCALED0 = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h40;
    // values
    localparam logic [6:0] PCT_MAX = 7'h64;
    localparam logic [6:0] PCT_RELEASE = 7'h66;
    localparam logic [11:0] FREQ_MIN = 12'h064;
    localparam logic [11:0] FREQ_MAX = 12'hfa0;
    localparam logic [11:0] FREQ_SYNC = 12'h376;
    localparam logic [6:0] RST_DIM = 7'h00;
    localparam logic [6:0] RST_RAMP = 7'h32;
    localparam logic [11:0] RST_FREQ = 12'h376;
    localparam logic [6:0] RST_MIX = 7'h32;
    localparam logic [20:0] RST_OVR_VAL = {7'h32, 7'h32, 7'h00};
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam int unsigned STAT_DIRECT_POS = 4;

    typedef enum logic [1:0] {
        PDO_AUX_DIM = 2'b00,
        PDO_AUX_OCC = 2'b01,
        PDO_AUX_CT_TUNE = 2'b10,
        PDO_AUX_CT_SEL = 2'b11
    } pdo_aux_e;

    // percent times percent, back to percent
    function automatic logic [6:0] mul_pct(input logic [6:0] a, input logic [6:0] b);
        logic [13:0] p;
        p = 14'(a) * 14'(b);
        return 7'(p / 14'd100);
    endfunction : mul_pct
endpackage : pdo_pkg

// ==== rtl/pdo_ramp.sv ====
// Purpose: slews one channel's duty toward its target one percent at a time
// Assumes: ms_tick is a one-cycle pulse every millisecond
// Notes: a step every ramp_setting ms, so a full 100 percent ramp takes ramp_setting x 0.1 s
`timescale 1ns/1ps
module pdo_ramp (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ms_tick,
    input wire logic [6:0] ramp_setting,
    input wire logic immediate,
    input wire logic [6:0] target,
    output logic [6:0] level
);
    logic [6:0] level_r, level_nxt;
    logic [6:0] cnt_r, cnt_nxt;

    // step timing, one step per ramp_setting ms whatever the distance
    always_comb begin
        level_nxt = level_r;
        cnt_nxt = cnt_r;
        if (immediate || ramp_setting == 7'h00) begin
            level_nxt = target;
            cnt_nxt = 7'h00;
        end else if (level_r == target) begin
            cnt_nxt = 7'h00;
        end else if (ms_tick) begin
            if (cnt_r + 7'h01 >= ramp_setting) begin
                cnt_nxt = 7'h00;
                level_nxt = (level_r < target) ? level_r + 7'h01 : level_r - 7'h01;
            end else begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 7'h00;
            cnt_r <= 7'h00;
        end else begin
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign level = level_r;
endmodule : pdo_ramp

// ==== rtl/pdo_top.sv ====
// Purpose: three-channel pwm stage with dim, blink, curve, ramp and per-channel overrides
// Assumes: apb slave, zero wait states; dim, aux and loop inputs already in percent
// Notes: out-of-range writes are ignored and leave the setting unchanged
`timescale 1ns/1ps
module pdo_top #(
    parameter int unsigned TICK_CYCLES = pdo_pkg::MS_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [6:0] loop_duty,
    input wire logic [6:0] dim_in_pct,
    input wire logic [6:0] aux_in_pct,
    input wire logic sync_in,
    output logic [2:0] pwm_out
);
    // settings
    logic [6:0] dim_r, dim_nxt;
    logic blink_r, blink_nxt;
    logic curve_r, curve_nxt;
    logic [6:0] ramp_r, ramp_nxt;
    logic [11:0] freq_r, freq_nxt;
    logic [6:0] mix_r, mix_nxt;
    pdo_pkg::pdo_aux_e aux_r, aux_nxt;
    logic [6:0] ovr_val_r [3];
    logic [6:0] ovr_val_nxt [3];
    logic [2:0] dir_r, dir_nxt;
    logic [2:0] scl_r, scl_nxt;
    // bus answer
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    // timing, blink, pwm
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic ms_tick_r, ms_tick_nxt;
    logic [9:0] blink_cnt_r, blink_cnt_nxt;
    logic blink_hi_r, blink_hi_nxt;
    logic [26:0] acc_r, acc_nxt;
    logic sync_d_r, sync_d_nxt;
    logic [2:0] pwm_r, pwm_nxt;
    // combinational
    logic [6:0] tgt [3];
    logic [6:0] level [3];
    logic [6:0] base [3];
    logic [15:0] status;
    logic wr_en, setup;
    logic [6:0] wval;
    logic [1:0] ch_sel;
    logic sync_rise;
    logic [26:0] acc_sum;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_r;
    assign wval = (pwdata[31:7] == 25'h0) ? pwdata[6:0] : 7'h7f;
    assign ch_sel = paddr[3:2];
    assign status = {9'h0, dir_r, 1'b0, scl_r};
    assign sync_rise = sync_in && !sync_d_r;

    // is this address one of the three channel slots at base
    function automatic logic is_ch(input logic [7:0] a, input logic [7:0] b);
        return a[7:4] == b[7:4] && a[1:0] == 2'b00 && a[3:2] != 2'b11;
    endfunction : is_ch

    // loop targets, dim curve and override scaling
    always_comb begin
        logic [6:0] lvl;
        lvl = curve_r ? pdo_pkg::mul_pct(dim_r, dim_r) : dim_r;
        base[0] = loop_duty;
        base[1] = mix_r;
        base[2] = pdo_pkg::PCT_MAX - mix_r;
        for (int i = 0; i < 3; i++) begin
            if (dir_r[i]) begin
                tgt[i] = ovr_val_r[i];
            end else if (scl_r[i]) begin
                if (aux_r == pdo_pkg::PDO_AUX_DIM) begin
                    tgt[i] = pdo_pkg::mul_pct(pdo_pkg::mul_pct(ovr_val_r[i], dim_in_pct), aux_in_pct);
                end else begin
                    tgt[i] = ovr_val_r[i];
                end
            end else begin
                tgt[i] = pdo_pkg::mul_pct(base[i], lvl);
            end
        end
    end

    // register writes and bus answer
    always_comb begin
        dim_nxt = dim_r;
        blink_nxt = blink_r;
        curve_nxt = curve_r;
        ramp_nxt = ramp_r;
        freq_nxt = freq_r;
        mix_nxt = mix_r;
        aux_nxt = aux_r;
        dir_nxt = dir_r;
        scl_nxt = scl_r;
        for (int i = 0; i < 3; i++) begin
            ovr_val_nxt[i] = ovr_val_r[i];
        end
        prdata_nxt = 32'h0;
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        if (wr_en) begin
            case (paddr)
                pdo_pkg::OFF_DIM: if (wval <= pdo_pkg::PCT_MAX) dim_nxt = wval;
                pdo_pkg::OFF_BLINK: if (pwdata[31:1] == 31'h0) blink_nxt = pwdata[0];
                pdo_pkg::OFF_CURVE: if (pwdata[31:1] == 31'h0) curve_nxt = pwdata[0];
                pdo_pkg::OFF_RAMP: if (wval <= pdo_pkg::PCT_MAX) ramp_nxt = wval;
                pdo_pkg::OFF_FREQ: begin
                    if (pwdata >= 32'(pdo_pkg::FREQ_MIN) && pwdata <= 32'(pdo_pkg::FREQ_MAX)) begin
                        freq_nxt = pwdata[11:0];
                    end
                end
                pdo_pkg::OFF_MIX: if (wval <= pdo_pkg::PCT_MAX) mix_nxt = wval;
                pdo_pkg::OFF_AUXMODE: if (pwdata[31:2] == 30'h0) aux_nxt = pdo_pkg::pdo_aux_e'(pwdata[1:0]);
                default: begin
                    if (is_ch(paddr, pdo_pkg::OFF_DIRECT0) || is_ch(paddr, pdo_pkg::OFF_SCALED0)) begin
                        if (wval == pdo_pkg::PCT_RELEASE) begin
                            dir_nxt[ch_sel] = 1'b0;
                            scl_nxt[ch_sel] = 1'b0;
                        end else if (wval <= pdo_pkg::PCT_MAX) begin
                            ovr_val_nxt[ch_sel] = wval;
                            dir_nxt[ch_sel] = paddr[7:4] == pdo_pkg::OFF_DIRECT0[7:4];
                            scl_nxt[ch_sel] = paddr[7:4] == pdo_pkg::OFF_SCALED0[7:4];
                        end
                    end
                end
            endcase
        end
        if (setup) begin
            case (paddr)
                pdo_pkg::OFF_DIM: prdata_nxt = {25'h0, dim_r};
                pdo_pkg::OFF_BLINK: prdata_nxt = {31'h0, blink_r};
                pdo_pkg::OFF_CURVE: prdata_nxt = {31'h0, curve_r};
                pdo_pkg::OFF_RAMP: prdata_nxt = {25'h0, ramp_r};
                pdo_pkg::OFF_FREQ: prdata_nxt = {20'h0, freq_r};
                pdo_pkg::OFF_MIX: prdata_nxt = {25'h0, mix_r};
                pdo_pkg::OFF_AUXMODE: prdata_nxt = {30'h0, aux_r};
                pdo_pkg::OFF_STATUS: prdata_nxt = {16'h0, status};
                default: begin
                    if (is_ch(paddr, pdo_pkg::OFF_DIRECT0) || is_ch(paddr, pdo_pkg::OFF_SCALED0)) begin
                        prdata_nxt = {25'h0, tgt[ch_sel]};
                    end else begin
                        pslverr_nxt = 1'b1;
                    end
                end
            endcase
            if (pwrite && paddr == pdo_pkg::OFF_STATUS) begin
                pslverr_nxt = 1'b1; // read-only word
            end
        end
    end

    // ms tick, blink phase, pwm accumulator with sync
    always_comb begin
        tick_cnt_nxt = tick_cnt_r + 32'h1;
        ms_tick_nxt = 1'b0;
        if (tick_cnt_r >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_nxt = 32'h0;
            ms_tick_nxt = 1'b1;
        end
        blink_cnt_nxt = blink_cnt_r;
        blink_hi_nxt = blink_hi_r;
        if (!blink_r) begin
            blink_cnt_nxt = 10'h0;
            blink_hi_nxt = 1'b0;
        end else if (ms_tick_r) begin
            if (blink_cnt_r >= 10'(pdo_pkg::BLINK_HALF_MS - 1)) begin
                blink_cnt_nxt = 10'h0;
                blink_hi_nxt = !blink_hi_r;
            end else begin
                blink_cnt_nxt = blink_cnt_r + 10'h1;
            end
        end
        acc_sum = acc_r + 27'(freq_r);
        acc_nxt = (acc_sum >= pdo_pkg::ACC_WRAP) ? acc_sum - pdo_pkg::ACC_WRAP : acc_sum;
        if (sync_rise && freq_r == pdo_pkg::FREQ_SYNC) begin
            acc_nxt = 27'h0;
        end
        sync_d_nxt = sync_in;
        for (int i = 0; i < 3; i++) begin
            if (blink_r) begin
                pwm_nxt[i] = blink_hi_r;
            end else begin
                pwm_nxt[i] = acc_r < 27'(level[i]) * pdo_pkg::DUTY_STEP;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dim_r <= pdo_pkg::RST_DIM;
            blink_r <= 1'b0;
            curve_r <= 1'b0;
            ramp_r <= pdo_pkg::RST_RAMP;
            freq_r <= pdo_pkg::RST_FREQ;
            mix_r <= pdo_pkg::RST_MIX;
            aux_r <= pdo_pkg::PDO_AUX_DIM;
            for (int i = 0; i < 3; i++) begin
                ovr_val_r[i] <= pdo_pkg::RST_OVR_VAL[7*i +: 7];
            end
            dir_r <= pdo_pkg::RST_STATUS[6:4];
            scl_r <= pdo_pkg::RST_STATUS[2:0];
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            tick_cnt_r <= 32'h0;
            ms_tick_r <= 1'b0;
            blink_cnt_r <= 10'h0;
            blink_hi_r <= 1'b0;
            acc_r <= 27'h0;
            sync_d_r <= 1'b0;
            pwm_r <= 3'h0;
        end else begin
            dim_r <= dim_nxt;
            blink_r <= blink_nxt;
            curve_r <= curve_nxt;
            ramp_r <= ramp_nxt;
            freq_r <= freq_nxt;
            mix_r <= mix_nxt;
            aux_r <= aux_nxt;
            ovr_val_r <= ovr_val_nxt;
            dir_r <= dir_nxt;
            scl_r <= scl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            ms_tick_r <= ms_tick_nxt;
            blink_cnt_r <= blink_cnt_nxt;
            blink_hi_r <= blink_hi_nxt;
            acc_r <= acc_nxt;
            sync_d_r <= sync_d_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    // per-channel slew, direct overrides jump at once
    for (genvar g = 0; g < 3; g++) begin : g_ramp
        pdo_ramp u_ramp (
            .pclk(pclk),
            .presetn(presetn),
            .ms_tick(ms_tick_r),
            .ramp_setting(ramp_r),
            .immediate(dir_r[g]),
            .target(tgt[g]),
            .level(level[g])
        );
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pwm_out = pwm_r;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dim_bad_ignored;
        wr_en && paddr == pdo_pkg::OFF_DIM && pwdata > 32'h64 |=> $stable(dim_r);
    endproperty
    a_dim_bad_ignored: assert property (p_dim_bad_ignored) else $error("dim took an out-of-range value");

    property p_blink_low;
        blink_r && !blink_hi_r |=> pwm_r == 3'h0;
    endproperty
    a_blink_low: assert property (p_blink_low) else $error("blink low phase not driving low");

    property p_linear_full;
        !curve_r && dim_r == 7'h64 && !dir_r[0] && !scl_r[0] |-> tgt[0] == loop_duty;
    endproperty
    a_linear_full: assert property (p_linear_full) else $error("linear curve at full dim is not unity");

    property p_ramp_zero;
        ramp_r == 7'h00 ##1 ramp_r == 7'h00 |-> level[0] == $past(tgt[0]);
    endproperty
    a_ramp_zero: assert property (p_ramp_zero) else $error("zero ramp did not follow at once");

    property p_ramp_hold;
        ramp_r != 7'h00 && !dir_r[1] && !ms_tick_r |=> level[1] == $past(level[1]);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("ramp stepped without a tick");

    property p_sync;
        sync_rise && freq_r == pdo_pkg::FREQ_SYNC |=> acc_r == 27'h0;
    endproperty
    a_sync: assert property (p_sync) else $error("sync edge did not restart the period");

    property p_freq_range;
        freq_r >= pdo_pkg::FREQ_MIN && freq_r <= pdo_pkg::FREQ_MAX;
    endproperty
    a_freq_range: assert property (p_freq_range) else $error("pwm frequency out of range");

    property p_direct_set;
        wr_en && paddr == pdo_pkg::OFF_DIRECT0 && pwdata <= 32'h64
            |=> status[4] && !status[0] ##1 level[0] == $past(pwdata[6:0], 2);
    endproperty
    a_direct_set: assert property (p_direct_set) else $error("direct override did not take channel 1");

    property p_release;
        wr_en && paddr == pdo_pkg::OFF_SCALED0 && pwdata == 32'h66 |=> !status[0] && !status[4];
    endproperty
    a_release: assert property (p_release) else $error("release did not hand channel back");

    property p_readback;
        setup && !pwrite && paddr == pdo_pkg::OFF_DIRECT0 |=> prdata_r == {25'h0, $past(tgt[0])} && pready_r;
    endproperty
    a_readback: assert property (p_readback) else $error("override readback wrong");

    property p_scaled;
        scl_r[1] && !dir_r[1] && aux_r == pdo_pkg::PDO_AUX_DIM && aux_in_pct == 7'h64 && dim_in_pct == 7'h00
            |-> tgt[1] == 7'h00;
    endproperty
    a_scaled: assert property (p_scaled) else $error("scaled override ignored dim input");

    property p_status;
        status[15:7] == 9'h0 && !status[3] && (dir_r & scl_r) == 3'h0;
    endproperty
    a_status: assert property (p_status) else $error("status word reserved or dual flags set");

    property p_mix;
        !curve_r && dim_r == 7'h64 && (dir_r[2:1] | scl_r[2:1]) == 2'b00 |-> tgt[1] + tgt[2] == pdo_pkg::PCT_MAX;
    endproperty
    a_mix: assert property (p_mix) else $error("string mix does not sum to full");

    c_blink: cover property (blink_r && blink_hi_r && pwm_r == 3'h7);
    c_direct: cover property (wr_en && paddr == pdo_pkg::OFF_DIRECT0 && pwdata <= 32'h64);
    c_sync: cover property (sync_rise && freq_r == pdo_pkg::FREQ_SYNC);
    c_ramp_step: cover property (ms_tick_r && level[1] != tgt[1] && ramp_r == 7'h01);
endmodule : pdo_top

// ==== tb/pdo_apb_host.sv ====
// Purpose: apb master standing in for the host that sets the pwm stage
// Assumes: zero or more wait states, answer sampled at the rising edge
// Notes: a hung transfer is reported back through the hung flag
`timescale 1ns/1ps
module pdo_apb_host (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one full setup and access cycle, held until pready is sampled high or 20 access edges have passed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : pdo_apb_host

// ==== tb/pdo_top_test.sv ====
// Purpose: self-checking bench for the pwm dim and override stage
// Assumes: ms tick shortened to 4 cycles
// Notes: expected values come from the register map and percent arithmetic
`timescale 1ns/1ps
module pdo_top_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] loop_duty, dim_in_pct, aux_in_pct;
    logic [2:0] pwm_out;
    int n_mismatch = 0;
    int comparisons = 0;

    pdo_top #(.TICK_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_duty(loop_duty), .dim_in_pct(dim_in_pct), .aux_in_pct(aux_in_pct),
        .sync_in(sync_in), .pwm_out(pwm_out));
    pdo_apb_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // clock generation
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // bus helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e, h;
        host_u.xfer(1'b1, a, d, r, e, h);
        if (h) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e, h;
        host_u.xfer(1'b0, a, 32'h0, r, e, h);
        if (h) begin
            n_mismatch++;
            complete_run();
        end
        chk(r, exp);
    endtask : rd

    task automatic errx(input logic w, input logic [7:0] a);
        logic [31:0] r;
        logic e, h;
        host_u.xfer(w, a, 32'h5, r, e, h);
        if (h) begin
            n_mismatch++;
            complete_run();
        end
        chk({31'h0, e}, 32'h1);
    endtask : errx

    task automatic t_reset;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h32);
        rd(8'h10, 32'h376);
        rd(8'h14, 32'h32);
        rd(8'h40, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_direct;
        wr(8'h20, 32'h25);
        rd(8'h20, 32'h25);
        wr(8'h24, 32'h64);
        wr(8'h28, 32'h0);
        rd(8'h40, 32'h70);
        wr(8'h20, 32'h65);
        rd(8'h20, 32'h25);
        wr(8'h20, 32'h66);
        rd(8'h40, 32'h60);
        $display("test direct done");
    endtask : t_direct

    task automatic t_scaled;
        wr(8'h30, 32'h50);
        rd(8'h30, 32'h14);
        rd(8'h40, 32'h61);
        wr(8'h18, 32'h1);
        rd(8'h20, 32'h50);
        wr(8'h18, 32'h0);
        aux_in_pct <= 7'h19;
        rd(8'h30, 32'ha);
        aux_in_pct <= 7'h32;
        wr(8'h30, 32'h66);
        rd(8'h40, 32'h60);
        $display("test scaled done");
    endtask : t_scaled

    task automatic t_loop;
        wr(8'h24, 32'h66);
        wr(8'h28, 32'h66);
        rd(8'h40, 32'h0);
        wr(8'h00, 32'h64);
        rd(8'h20, 32'h3c);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h32);
        rd(8'h20, 32'hf);
        wr(8'h14, 32'h1e);
        rd(8'h24, 32'h7);
        rd(8'h28, 32'h11);
        $display("test loop done");
    endtask : t_loop

    task automatic t_regs;
        wr(8'h10, 32'h63);
        rd(8'h10, 32'h376);
        wr(8'h10, 32'hfa0);
        rd(8'h10, 32'hfa0);
        wr(8'h10, 32'h376);
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h18, 32'h3);
        rd(8'h18, 32'h3);
        wr(8'h18, 32'h4);
        rd(8'h18, 32'h3);
        wr(8'h18, 32'h0);
        errx(1'b0, 8'h44);
        errx(1'b1, 8'h40);
        rd(8'h40, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_pwm;
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h64);
        wr(8'h20, 32'h64);
        wr(8'h24, 32'h0);
        repeat (5) @(posedge pclk);
        for (int i = 0; i < 30; i++) begin
            @(posedge pclk);
            chk({30'h0, pwm_out[1:0]}, 32'h1);
        end
        wr(8'h04, 32'h1);
        repeat (1000) @(posedge pclk);
        chk({29'h0, pwm_out}, 32'h0);
        repeat (2000) @(posedge pclk);
        chk({29'h0, pwm_out}, 32'h7);
        wr(8'h04, 32'h0);
        repeat (5) @(posedge pclk);
        chk({30'h0, pwm_out[1:0]}, 32'h1);
        $display("test pwm done");
    endtask : t_pwm

    // one rising edge on the sync pin, then let the restarted period settle
    task automatic pulse_sync;
        @(posedge pclk);
        sync_in <= 1'b1;
        repeat (2) @(posedge pclk);
        sync_in <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse_sync

    // channel 1 at 1 percent is high only just after a period restart
    task automatic t_sync;
        wr(8'h20, 32'h1);
        wr(8'h10, 32'h377);
        pulse_sync();
        chk({31'h0, pwm_out[0]}, 32'h0);
        wr(8'h10, 32'h376);
        pulse_sync();
        chk({31'h0, pwm_out[0]}, 32'h1);
        wr(8'h0c, 32'h1);
        wr(8'h30, 32'h32);
        rd(8'h30, 32'hc);
        $display("test sync done");
    endtask : t_sync

    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // reset then scenarios
    initial begin
        presetn = 1'b0;
        loop_duty = 7'h3c;
        dim_in_pct = 7'h32;
        aux_in_pct = 7'h32;
        sync_in = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_direct();
        t_scaled();
        t_loop();
        t_regs();
        t_pwm();
        t_sync();
        complete_run();
    end
endmodule : pdo_top_test
